// [ccr_regs.sv]
// Purpose: configuration register bank reached through index/data i/o ports
// Assumes: i/o strobes are one-cycle pulses synchronous to i_mclk
// Notes: control register 2 (21h) is held only for its two leadoff bits
`timescale 1ns/1ps
module ccr_regs
  import ccr_pkg::*;
#(
  parameter logic [1:0] REVISION = 2'h3 // arbitrary revision code
)(
  input wire logic i_mclk, // cpu bus clock
  input wire logic i_resetn, // sync reset, active low
  input wire logic i_ce, // clock enable
  input wire ccr_pkg::ccr_io_type i_io, // i/o cycle
  output logic [7:0] o_rdata, // read data, registered
  input wire logic i_strap_mode, // cache_mode_strap level
  input wire logic i_halt, // halt cycle seen, pulse
  input wire logic [26:0] i_addr, // memory address
  output ccr_pkg::ccr_cfg_type o_cfg, // decoded settings
  output logic o_non_cacheable, // address in uncached block
  output logic o_l2_cacheable, // address in l2-cacheable segment
  output logic o_cpu_reset // cpu reset pulse
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [7:0] index;
    logic [5:0] ctrl1;
    logic [1:0] ctrl2;
    logic [7:0] nc1_hi;
    logic [7:0] nc1_lo;
    logic [7:0] nc2_hi;
    logic [7:0] nc2_lo;
    logic [7:0] boot;
    logic [7:0] rng_up;
    logic [7:0] rng_lo;
    logic [7:0] rdata;
    logic strap;
    logic strap_taken;
    logic kbd_pending;
    logic [2:0] rst_cnt;
  } ccr_state_type;

  ccr_state_type st;
  ccr_state_type next_st;

  // size encoding: block spans 64KB << (size - 1) (size 0 = off)
  function automatic logic in_block(input logic [7:0] hi, input logic [7:0] lo,
                                    input logic [26:0] a);
    logic [10:0] base;
    logic [10:0] mask;
    base = {hi[2:0], lo};
    mask = 11'h7ff << (hi[7:5] - 3'h1);
    in_block = (hi[7:5] != 3'h0) && ((a[26:16] & mask) == (base & mask));
  endfunction : in_block

  wire logic io_data = i_io.port == CCR_PORT_DATA;
  wire logic kbd_wr = i_io.wr && i_io.port == CCR_PORT_KBD;
  wire logic halt_rst = i_halt && (st.ctrl1[CCR_BIT_FASTRST] || st.kbd_pending);

  always_comb
  begin
    next_st = st;
    if (!st.strap_taken)
    begin
      next_st.strap = i_strap_mode; // strap caught after reset release
      next_st.strap_taken = 1'b1;
    end
    if (i_io.wr && i_io.port == CCR_PORT_INDEX)
      next_st.index = i_io.data;
    if (i_io.wr && io_data)
    begin
      unique case (st.index)
        CCR_IDX_CTRL1: next_st.ctrl1 = i_io.data[5:0] & CCR_CTRL1_WMASK;
        CCR_IDX_CTRL2: next_st.ctrl2 = i_io.data[1:0];
        CCR_IDX_NC1_HI: next_st.nc1_hi = i_io.data & CCR_NC_HI_MASK;
        CCR_IDX_NC1_LO: next_st.nc1_lo = i_io.data;
        CCR_IDX_NC2_HI: next_st.nc2_hi = i_io.data & CCR_NC_HI_MASK;
        CCR_IDX_NC2_LO: next_st.nc2_lo = i_io.data;
        CCR_IDX_BOOT: next_st.boot = i_io.data;
        CCR_IDX_RNG_UP: next_st.rng_up = i_io.data;
        CCR_IDX_RNG_LO: next_st.rng_lo = i_io.data;
        default: ;
      endcase
    end
    if (i_io.rd && io_data)
    begin
      unique case (st.index)
        CCR_IDX_CTRL1: next_st.rdata = {REVISION, st.ctrl1};
        CCR_IDX_CTRL2: next_st.rdata = {6'h00, st.ctrl2};
        CCR_IDX_NC1_HI: next_st.rdata = st.nc1_hi;
        CCR_IDX_NC1_LO: next_st.rdata = st.nc1_lo;
        CCR_IDX_NC2_HI: next_st.rdata = st.nc2_hi;
        CCR_IDX_NC2_LO: next_st.rdata = st.nc2_lo;
        CCR_IDX_BOOT: next_st.rdata = st.boot;
        CCR_IDX_RNG_UP: next_st.rdata = st.rng_up;
        CCR_IDX_RNG_LO: next_st.rdata = st.rng_lo;
        default: next_st.rdata = 8'hff; // 2ch and others float high
      endcase
    end
    // a pending keyboard reset is consumed by the halt or write that fires it
    if (halt_rst || (kbd_wr && st.ctrl1[CCR_BIT_KBDRST]))
      next_st.kbd_pending = 1'b0;
    // a new deferred request in the same cycle wins over the clear
    if (kbd_wr && !st.ctrl1[CCR_BIT_KBDRST])
      next_st.kbd_pending = 1'b1;
    if (st.rst_cnt != 3'h0)
      next_st.rst_cnt = st.rst_cnt - 3'h1;
    if ((kbd_wr && st.ctrl1[CCR_BIT_KBDRST]) || halt_rst)
      next_st.rst_cnt = 3'(CCR_RST_PULSE_CYC);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      st <= '0;
      st.ctrl1 <= CCR_RESET_VAL[5:0];
    end
    else if (i_ce)
      st <= next_st;
  end

  logic [19:0] a20;
  logic [3:0] seg;
  always_comb
  begin
    a20 = i_addr[19:0];
    seg = 4'((a20 - CCR_SEG_BASE_LO) >> CCR_SEG_SHIFT);
    o_l2_cacheable = 1'b0;
    if (a20 >= CCR_SEG_BASE_LO && a20 < CCR_SEG_BASE_UP && i_addr[26:20] == 7'h00)
      o_l2_cacheable = st.rng_lo[seg[2:0]];
    else if (a20 >= CCR_SEG_BASE_UP && seg < 4'hb && i_addr[26:20] == 7'h00)
      o_l2_cacheable = st.rng_up[seg[1:0]] && seg[3];
  end

  assign o_non_cacheable = in_block(st.nc1_hi, st.nc1_lo, i_addr)
                        || in_block(st.nc2_hi, st.nc2_lo, i_addr);
  assign o_rdata = st.rdata;
  assign o_cpu_reset = st.rst_cnt != 3'h0;
  assign o_cfg.burst_x2 = st.ctrl1[CCR_BIT_BURST];
  assign o_cfg.tag_sample_en = !st.strap && !st.ctrl1[CCR_BIT_TAG];
  assign o_cfg.single_ale = st.ctrl1[CCR_BIT_ALE];
  assign o_cfg.at_wait = st.ctrl1[CCR_BIT_ATWS];
  assign o_cfg.read_lead_fast = st.ctrl2[0];
  assign o_cfg.write_lead_fast = st.ctrl2[1];
  assign o_cfg.l1_upper = st.rng_up[7:5];

  property p_fast_rst;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && i_halt && st.ctrl1[CCR_BIT_FASTRST]) |=> o_cpu_reset;
  endproperty
  a_fast_rst: assert property (p_fast_rst) else $error("halt gave no reset");

  property p_kbd_now;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && kbd_wr && st.ctrl1[CCR_BIT_KBDRST]) |=> o_cpu_reset;
  endproperty
  a_kbd_now: assert property (p_kbd_now) else $error("kbd write gave no reset");

  property p_kbd_wait;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && kbd_wr && !st.ctrl1[CCR_BIT_KBDRST] && !i_halt && !o_cpu_reset)
      |=> !o_cpu_reset && st.kbd_pending;
  endproperty
  a_kbd_wait: assert property (p_kbd_wait) else $error("kbd reset not deferred");

  property p_kbd_set;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && kbd_wr && !st.ctrl1[CCR_BIT_KBDRST]) |=> st.kbd_pending;
  endproperty
  a_kbd_set: assert property (p_kbd_set) else $error("deferred kbd reset lost");

  property p_rev;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && i_io.rd && io_data && st.index == CCR_IDX_CTRL1) |=> o_rdata[7:6] == REVISION;
  endproperty
  a_rev: assert property (p_rev) else $error("revision bits wrong");

  property p_index;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && i_io.wr && i_io.port == CCR_PORT_INDEX) |=> st.index == $past(i_io.data);
  endproperty
  a_index: assert property (p_index) else $error("index not taken");

  property p_burst;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && i_io.wr && io_data && st.index == CCR_IDX_CTRL1)
      |=> o_cfg.burst_x2 == $past(i_io.data[5]) && o_cfg.at_wait == $past(i_io.data[2]);
  endproperty
  a_burst: assert property (p_burst) else $error("control bits not stored");

  property p_tag;
    @(posedge i_mclk) disable iff (!i_resetn)
      st.strap |-> !o_cfg.tag_sample_en;
  endproperty
  a_tag: assert property (p_tag) else $error("tag sampling with strap high");

  property p_nc_unused;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && i_io.wr && io_data && st.index == CCR_IDX_NC1_HI) |=> st.nc1_hi[4:3] == 2'h0;
  endproperty
  a_nc_unused: assert property (p_nc_unused) else $error("unused bits stored");

  property p_seg_c0;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_addr[26:14] == 13'h0030) |-> o_l2_cacheable == st.rng_lo[0];
  endproperty
  a_seg_c0: assert property (p_seg_c0) else $error("c0000 segment lookup wrong");
endmodule : ccr_regs

// [ccr_pkg.sv]
// Purpose: shared constants and carriers for the configuration register bank
// Assumes: 8-bit index/data i/o port pair on the cpu bus clock
// Notes: offsets are register indices behind the data port
package ccr_pkg;
  localparam logic [15:0] CCR_PORT_INDEX = 16'h0022;
  localparam logic [15:0] CCR_PORT_DATA = 16'h0024;
  localparam logic [15:0] CCR_PORT_KBD = 16'h0064;
  localparam logic [7:0] CCR_IDX_CTRL1 = 8'h20;
  localparam logic [7:0] CCR_IDX_CTRL2 = 8'h21;
  localparam logic [7:0] CCR_IDX_NC1_HI = 8'h28;
  localparam logic [7:0] CCR_IDX_NC1_LO = 8'h29;
  localparam logic [7:0] CCR_IDX_NC2_HI = 8'h2a;
  localparam logic [7:0] CCR_IDX_NC2_LO = 8'h2b;
  localparam logic [7:0] CCR_IDX_BOOT = 8'h2d;
  localparam logic [7:0] CCR_IDX_RNG_UP = 8'h2e;
  localparam logic [7:0] CCR_IDX_RNG_LO = 8'h2f;
  localparam int CCR_BIT_BURST = 5;
  localparam int CCR_BIT_TAG = 4;
  localparam int CCR_BIT_ALE = 3;
  localparam int CCR_BIT_ATWS = 2;
  localparam int CCR_BIT_KBDRST = 1;
  localparam int CCR_BIT_FASTRST = 0;
  localparam logic [7:0] CCR_RESET_VAL = 8'h00;
  localparam logic [5:0] CCR_CTRL1_WMASK = 6'h3f;
  localparam logic [7:0] CCR_NC_HI_MASK = 8'he7;
  localparam logic [19:0] CCR_SEG_BASE_LO = 20'hc0000;
  localparam logic [19:0] CCR_SEG_BASE_UP = 20'he0000;
  localparam int CCR_SEG_SHIFT = 14;
  localparam int CCR_RST_PULSE_CYC = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] port;
    logic [7:0] data;
  } ccr_io_type;

  typedef struct packed {
    logic burst_x2;
    logic tag_sample_en;
    logic single_ale;
    logic at_wait;
    logic read_lead_fast;
    logic write_lead_fast;
    logic [2:0] l1_upper;
  } ccr_cfg_type;
endpackage : ccr_pkg

// [ccr_regs_tb.sv]
// Purpose: self-checking bench for the configuration register bank
// Assumes: one-cycle i/o strobes, strap held low through the first reset
// Notes: every compare goes through chk; a watchdog cuts a hang short
`timescale 1ns/1ps
module ccr_regs_tb;
  import ccr_pkg::*;
  localparam logic [1:0] REV = 2'h3; // arbitrary revision code
  logic i_mclk, i_resetn, i_strap_mode, i_halt;
  ccr_io_type i_io;
  logic [26:0] i_addr;
  logic [7:0] o_rdata;
  ccr_cfg_type o_cfg;
  logic o_non_cacheable, o_l2_cacheable, o_cpu_reset;
  int miscompares = 0;
  int compares = 0;
  int n;

  ccr_regs #(.REVISION(REV)) dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(1'b1),
    .i_io(i_io), .o_rdata(o_rdata), .i_strap_mode(i_strap_mode), .i_halt(i_halt),
    .i_addr(i_addr), .o_cfg(o_cfg), .o_non_cacheable(o_non_cacheable),
    .o_l2_cacheable(o_l2_cacheable), .o_cpu_reset(o_cpu_reset));

  initial
  begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one strobe cycle; returns just after the edge that takes it
  task automatic io(input logic rd, input logic [15:0] port, input logic [7:0] d);
    @(posedge i_mclk);
    i_io <= '{wr: ~rd, rd: rd, port: port, data: d};
    @(posedge i_mclk);
    i_io <= '0;
    #1;
  endtask : io

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    io(1'b0, CCR_PORT_INDEX, idx);
    io(1'b0, CCR_PORT_DATA, d);
  endtask : wreg

  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp, input string what);
    io(1'b0, CCR_PORT_INDEX, idx);
    io(1'b1, CCR_PORT_DATA, 8'h00);
    chk(what, o_rdata, exp);
  endtask : rreg

  task automatic probe(input logic [26:0] a, input logic [1:0] exp, input string what);
    @(posedge i_mclk);
    i_addr <= a;
    #1;
    chk(what, {6'h00, o_non_cacheable, o_l2_cacheable}, {6'h00, exp});
  endtask : probe

  // counts reset cycles over a window longer than the pulse
  task automatic count_rst(input logic [7:0] exp, input string what);
    n = 0;
    repeat (8)
    begin
      if (o_cpu_reset === 1'b1) n++;
      @(posedge i_mclk);
      #1;
    end
    chk(what, 8'(n), exp);
  endtask : count_rst

  task automatic halt();
    @(posedge i_mclk);
    i_halt <= 1'b1;
    @(posedge i_mclk);
    i_halt <= 1'b0;
    #1;
  endtask : halt

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    miscompares++;
    $display("watchdog expired");
    final_report();
  end

  initial
  begin
    i_resetn = 1'b0;
    i_io = '0;
    i_halt = 1'b0;
    i_strap_mode = 1'b0;
    i_addr = '0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rreg(CCR_IDX_CTRL1, {REV, 6'h00}, "ctrl1 reset");
    chk("tag on", 8'(o_cfg.tag_sample_en), 8'h01);
    wreg(CCR_IDX_CTRL1, 8'hff);
    rreg(CCR_IDX_CTRL1, {REV, 6'h3f}, "ctrl1 rev");
    chk("cfg set", {4'h0, o_cfg.burst_x2, o_cfg.tag_sample_en, o_cfg.single_ale, o_cfg.at_wait},
      8'h0b);
    wreg(CCR_IDX_CTRL1, 8'h00);
    chk("cfg clr", {5'h00, o_cfg.burst_x2, o_cfg.single_ale, o_cfg.at_wait}, 8'h00);
    wreg(CCR_IDX_CTRL2, 8'h01);
    chk("lead", {5'h00, o_cfg.read_lead_fast, o_cfg.write_lead_fast, o_cfg.burst_x2}, 8'h04);
    wreg(CCR_IDX_CTRL2, 8'h02);
    chk("lead wr", {5'h00, o_cfg.read_lead_fast, o_cfg.write_lead_fast, o_cfg.burst_x2}, 8'h02);
    $display("test ctrl done");
    wreg(CCR_IDX_NC1_HI, 8'hff);
    rreg(CCR_IDX_NC1_HI, 8'he7, "nc1 hi");
    wreg(CCR_IDX_NC2_LO, 8'h5a);
    rreg(CCR_IDX_NC2_LO, 8'h5a, "nc2 lo");
    rreg(8'h2c, 8'hff, "unmapped");
    wreg(CCR_IDX_NC1_HI, 8'h21);
    wreg(CCR_IDX_NC1_LO, 8'h10);
    wreg(CCR_IDX_NC2_HI, 8'h20);
    probe(27'h1100000, 2'b10, "nc1 hit");
    probe(27'h1110000, 2'b00, "nc1 miss");
    probe(27'h05a1234, 2'b10, "nc2 hit");
    $display("test blocks done");
    wreg(CCR_IDX_RNG_LO, 8'h81);
    probe(27'h00c0000, 2'b01, "seg c0");
    probe(27'h00c4000, 2'b00, "seg c4");
    probe(27'h00dfff0, 2'b01, "seg dc");
    wreg(CCR_IDX_RNG_UP, 8'ha4);
    probe(27'h00e8000, 2'b01, "seg e8");
    probe(27'h00e0000, 2'b00, "seg e0");
    chk("l1 field", 8'(o_cfg.l1_upper), 8'h05);
    $display("test ranges done");
    wreg(CCR_IDX_CTRL1, 8'h02);
    io(1'b0, CCR_PORT_KBD, 8'h00);
    count_rst(8'h04, "kbd now");
    wreg(CCR_IDX_CTRL1, 8'h00);
    io(1'b0, CCR_PORT_KBD, 8'h00);
    count_rst(8'h00, "kbd wait");
    halt();
    count_rst(8'h04, "kbd halt");
    halt();
    count_rst(8'h00, "halt idle");
    wreg(CCR_IDX_CTRL1, 8'h01);
    repeat (2)
    begin
      halt();
      count_rst(8'h04, "fast rst");
    end
    $display("test resets done");
    // second reset with the strap high: tag sampling must stay off
    @(posedge i_mclk);
    i_strap_mode <= 1'b1;
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
    #1;
    chk("tag strap", 8'(o_cfg.tag_sample_en), 8'h00);
    rreg(CCR_IDX_CTRL1, {REV, 6'h00}, "ctrl1 rerun");
    $display("test strap done");
    final_report();
  end
endmodule : ccr_regs_tb
